/* nfs_feature_status.sv */
// Purpose: Feature registers and status output for one NAND die.
// Assumes: Host pins are asynchronous and are synchronised here.
// Notes: Commands are taken on the rising edge of the write strobe.
`timescale 1ns/1ps
module nfs_feature_status
    import nfs_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // Register port.
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Host bus pins.
    input wire nfs_bus_t bus_in,
    // Array engine state.
    input wire nfs_array_t arr_in,
    // Data lines and strobe.
    output logic [7:0] dq_out,
    output logic dq_oe_out,
    output logic dqs_out,
    output logic dqs_oe_out,
    // Feature outputs.
    output logic [1:0] pulldown_strength_out,
    output logic [1:0] read_retry_out,
    output logic otp_mode_out,
    output logic status_mode_out
);
    // ==========================================================
    // Pin synchronisers.
    localparam int BW = $bits(nfs_bus_t);
    // Synchronisers reset to idle pin levels, so no false strobe edge or chip enable follows reset.
    localparam nfs_bus_t BUS_IDLE = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, read_strobe_n: 1'b1,
        wr_n: 1'b1, sync_mode: 1'b0, dq: 8'h00};
    nfs_bus_t bus_s;
    logic [BW-1:0] bus_raw;
    nfs_sync #(.W(BW)) u_sync (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .d_in(bus_in),
        .rst_val_in(BUS_IDLE),
        .q_out(bus_raw)
    );
    assign bus_s = nfs_bus_t'(bus_raw);

    // ==========================================================
    // Registers.
    logic [7:0] pulldown_q;
    logic [7:0] retry_q;
    logic [7:0] array_mode_q;
    nfs_state_t state_q;
    nfs_state_t state_d;
    logic enhanced_q;
    logic enhanced_d;
    logic plane_q;
    logic plane_d;
    logic [1:0] row_cnt_q;
    logic [1:0] row_cnt_d;
    logic we_prev_q;
    logic dqs_q;
    logic [7:0] dq_q;
    logic dq_oe_q;
    logic [7:0] rdata_q;
    logic [7:0] status_w;

    // ==========================================================
    // Bus cycle decode.
    wire we_rise = bus_s.we_n & ~we_prev_q;
    wire ce_act = ~bus_s.ce_n;
    wire cmd_cycle = ce_act & bus_s.cle & ~bus_s.ale & we_rise;
    wire addr_cycle = ce_act & bus_s.ale & ~bus_s.cle & we_rise;
    wire is_status_cmd = (bus_s.dq == NFS_CMD_STATUS) | (bus_s.dq == NFS_CMD_STATUS_ENH);
    wire is_enh_cmd = (bus_s.dq == NFS_CMD_STATUS_ENH);
    wire is_reset_cmd = cmd_cycle & (bus_s.dq == NFS_CMD_RESET);
    wire in_status = (state_q == NFS_STATUS_OUT);
    // Asynchronous output window.
    wire async_rd = ~bus_s.sync_mode & ce_act & ~bus_s.read_strobe_n;
    // Synchronous status window.
    wire sync_rd = bus_s.sync_mode & ce_act & ~bus_s.wr_n & bus_s.ale & bus_s.cle;
    wire rd_win = in_status & (async_rd | sync_rd);

    // ==========================================================
    // Register writes: reserved bits are kept at zero whatever the host writes.
    wire wr_pd = reg_wr_in & (reg_addr_in == NFS_ADDR_PULLDOWN);
    wire wr_rt = reg_wr_in & (reg_addr_in == NFS_ADDR_RETRY);
    wire wr_am = reg_wr_in & (reg_addr_in == NFS_ADDR_ARRAY_MODE);

    // [RULE2] full strength reset
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            pulldown_q <= NFS_FEAT_RESET;
        end else if (wr_pd) begin
            // [RULE1] two low bits
            pulldown_q <= reg_wdata_in & NFS_MASK_TWO_BITS;
        end
    end

    // [RULE3] retry option decode
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            retry_q <= NFS_FEAT_RESET;
        end else if (wr_rt) begin
            retry_q <= reg_wdata_in & NFS_MASK_TWO_BITS;
        end
    end

    // A reset command arriving with a write wins, since it restores normal access.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            array_mode_q <= NFS_FEAT_RESET;
        end else if (is_reset_cmd) begin
            // [RULE5] reset to normal
            array_mode_q <= NFS_FEAT_RESET;
        end else if (wr_am) begin
            // [RULE4] bit zero mode
            array_mode_q <= reg_wdata_in & NFS_MASK_ONE_BIT;
        end
    end

    assign pulldown_strength_out = pulldown_q[1:0];
    assign read_retry_out = retry_q[1:0];
    assign otp_mode_out = array_mode_q[0];

    // ==========================================================
    // Status command state machine.
    always_comb begin
        state_d = state_q;
        enhanced_d = enhanced_q;
        plane_d = plane_q;
        row_cnt_d = row_cnt_q;
        case (state_q)
            NFS_IDLE, NFS_STATUS_OUT: begin
                if (cmd_cycle) begin
                    // [RULE15] leave on next command
                    state_d = NFS_IDLE;
                    if (bus_s.dq == NFS_CMD_STATUS) begin
                        // [RULE7] [RULE13] plain status
                        state_d = NFS_STATUS_OUT;
                        enhanced_d = 1'b0;
                    end else if (bus_s.dq == NFS_CMD_STATUS_ENH) begin
                        state_d = NFS_ENH_ADDR;
                        enhanced_d = 1'b1;
                        row_cnt_d = 2'h0;
                    end
                end
            end
            NFS_ENH_ADDR: begin
                if (cmd_cycle) begin
                    // A command mid-address restarts decode, so a status command still takes effect.
                    state_d = ~is_status_cmd ? NFS_IDLE : (is_enh_cmd ? NFS_ENH_ADDR : NFS_STATUS_OUT);
                    enhanced_d = is_enh_cmd;
                    row_cnt_d = 2'h0;
                end else if (addr_cycle) begin
                    // First row cycle carries the plane bit in its low bit.
                    if (row_cnt_q == 2'h0) begin
                        plane_d = bus_s.dq[0];
                    end
                    row_cnt_d = row_cnt_q + 2'h1;
                    if (row_cnt_q + 2'h1 == NFS_ENH_ROW_CYCLES) begin
                        // [RULE7] enhanced status
                        state_d = arr_in.selected ? NFS_STATUS_OUT : NFS_IDLE;
                    end
                end
            end
            default: begin
                state_d = NFS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            state_q <= NFS_IDLE;
            enhanced_q <= 1'b0;
            plane_q <= 1'b0;
            row_cnt_q <= 2'h0;
            we_prev_q <= 1'b1;
        end else begin
            state_q <= state_d;
            enhanced_q <= enhanced_d;
            plane_q <= plane_d;
            row_cnt_q <= row_cnt_d;
            we_prev_q <= bus_s.we_n;
        end
    end

    // ==========================================================
    // [RULE6] own status byte
    nfs_status_mux u_mux (
        .arr_in(arr_in),
        .enhanced_in(enhanced_q),
        .plane_in(plane_q),
        .status_out(status_w)
    );

    // Data lines follow status every cycle of the window, so no read strobe edge is needed.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            dq_q <= 8'h00;
            dq_oe_q <= 1'b0;
            dqs_q <= 1'b0;
        end else begin
            // [RULE8] [RULE9] [RULE10] live status
            dq_q <= rd_win ? status_w : 8'h00;
            dq_oe_q <= rd_win;
            // [RULE11] strobe toggles
            dqs_q <= (in_status & sync_rd) ? ~dqs_q : 1'b0;
        end
    end

    assign dq_out = dq_q;
    assign dq_oe_out = dq_oe_q;
    assign dqs_out = dqs_q;
    assign dqs_oe_out = dq_oe_q & bus_s.sync_mode;
    assign status_mode_out = in_status;

    // ==========================================================
    // Register reads; unmapped addresses read zero.
    wire [7:0] rd_mux = (reg_addr_in == NFS_ADDR_PULLDOWN) ? pulldown_q :
                        (reg_addr_in == NFS_ADDR_RETRY) ? retry_q :
                        (reg_addr_in == NFS_ADDR_ARRAY_MODE) ? array_mode_q :
                        (reg_addr_in == NFS_ADDR_STATUS) ? status_w : 8'h00;
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= reg_rd_in ? rd_mux : 8'h00;
        end
    end
    assign reg_rdata_out = rdata_q;
endmodule : nfs_feature_status

/* nfs_pkg.sv */
// Purpose: Constants and types for the NAND feature and status logic.
// Assumes: One die, two planes, host bus pins synchronised into the core clock by nfs_sync.
// Notes: Feature registers sit at their feature addresses on the register port.
// What this block does
// [RULE1] Pull-down strength from two low bits: 01h three-quarter, 02h half, 03h quarter.
// [RULE2] Pull-down strength resets to full strength, value 00h.
// [RULE3] Read retry: two low bits, 00h disabled default, 01h-03h options.
// [RULE4] Array mode bit 0: 0 normal default, 1 one-time-programmable area.
// [RULE5] Reset command returns array mode to normal.
// [RULE6] The die keeps its own 8-bit status register.
// [RULE7] Plain or enhanced status command enters status output mode.
// [RULE8] Each data output request in status mode returns the status register.
// [RULE9] Asynchronous status follows live while chip enable and read strobe low.
// [RULE10] Synchronous status live when chip enable, direction low and both latches high.
// [RULE11] Synchronous status toggles data strobe while both latch enables high.
// [RULE12] Host sends read mode after polling a transfer to leave status mode.
// [RULE13] Plain status reports this die when last selected, even while busy.
// [RULE14] Host uses enhanced status in multi-die work so one die drives.
// [RULE15] Status mode holds until next valid command that is not a status command; code leaves it on 78h until the row address is taken.
// [RULE16] Host writes zero to reserved bits and uses listed encodings only.
// [RULE17] Status bit 6 is 0 while the die is busy, 1 when ready.
// [RULE18] Status bit 5 is low while any plane runs an array operation.
// [RULE19] Status bit 0 shows last program or erase failure, valid when bit 5 high.
// [RULE20] Plain status ORs plane failures; enhanced reports the addressed plane.
package nfs_pkg;
    // ==========================================================
    // Register map and fields
    localparam logic [7:0] NFS_ADDR_PULLDOWN = 8'h81;
    localparam logic [7:0] NFS_ADDR_RETRY = 8'h89;
    localparam logic [7:0] NFS_ADDR_ARRAY_MODE = 8'h90;
    localparam logic [7:0] NFS_ADDR_STATUS = 8'h70;
    localparam logic [7:0] NFS_FEAT_RESET = 8'h00;
    localparam logic [7:0] NFS_MASK_TWO_BITS = 8'h03;
    localparam logic [7:0] NFS_MASK_ONE_BIT = 8'h01;
    localparam int NFS_SR_WP = 7;
    localparam int NFS_SR_RDY = 6;
    localparam int NFS_SR_ARRAY_READY_BIT = 5;
    localparam int NFS_SR_PREV_OP_ERROR_BIT = 1;
    localparam int NFS_SR_FAIL = 0;
    localparam int NFS_PLANES = 2;
    // ==========================================================
    // Commands
    localparam logic [7:0] NFS_CMD_STATUS = 8'h70;
    localparam logic [7:0] NFS_CMD_STATUS_ENH = 8'h78;
    localparam logic [7:0] NFS_CMD_READ_MODE = 8'h00;
    localparam logic [7:0] NFS_CMD_RESET = 8'hff;
    localparam logic [1:0] NFS_ENH_ROW_CYCLES = 2'h3;

    typedef enum logic [1:0] {
        NFS_IDLE = 2'b00,
        NFS_ENH_ADDR = 2'b01,
        NFS_STATUS_OUT = 2'b10
    } nfs_state_t;

    typedef enum logic [1:0] {
        NFS_PD_FULL = 2'b00,
        NFS_PD_THREE_QUARTER = 2'b01,
        NFS_PD_HALF = 2'b10,
        NFS_PD_QUARTER = 2'b11
    } nfs_pulldown_t;

    // Host bus pins as seen by the core.
    typedef struct packed {
        logic ce_n;
        logic cle;
        logic ale;
        logic we_n;
        logic read_strobe_n;
        logic wr_n;
        logic sync_mode;
        logic [7:0] dq;
    } nfs_bus_t;

    // Die and per-plane array state from the array engine.
    typedef struct packed {
        logic busy;
        logic [NFS_PLANES-1:0] array_busy;
        logic [NFS_PLANES-1:0] fail;
        logic [NFS_PLANES-1:0] prev_op_error_bit;
        logic wp_n;
        logic selected;
    } nfs_array_t;
endpackage : nfs_pkg

/* nfs_sync.sv */
// Purpose: Two-flop synchroniser for a vector of pins.
// Assumes: Inputs are asynchronous to the core clock.
// Notes: The first stage feeds only the second.
`timescale 1ns/1ps
module nfs_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // Data.
    input wire logic [W-1:0] d_in,
    input wire logic [W-1:0] rst_val_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    // ==========================================================
    // Two stages; reset value is held as a constant by the caller.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            s1_q <= rst_val_in;
            s2_q <= rst_val_in;
        end else begin
            s1_q <= d_in;
            s2_q <= s1_q;
        end
    end
    assign q_out = s2_q;
endmodule : nfs_sync

/* nfs_status_mux.sv */
// Purpose: Builds the 8-bit status byte for plain or enhanced status.
// Assumes: Plane failure bits come from the array engine.
// Notes: Purely combinational.
`timescale 1ns/1ps
module nfs_status_mux
    import nfs_pkg::*;
(
    // Array state.
    input wire nfs_array_t arr_in,
    // Selection.
    input wire logic enhanced_in,
    input wire logic plane_in,
    // Status byte.
    output logic [7:0] status_out
);
    wire fail_sel;
    wire prev_op_error_bit_sel;
    wire [7:0] status_w;
    // ==========================================================
    // [RULE20] plane fail select
    assign fail_sel = enhanced_in ? arr_in.fail[plane_in] : (|arr_in.fail);
    assign prev_op_error_bit_sel = enhanced_in ? arr_in.prev_op_error_bit[plane_in] : (|arr_in.prev_op_error_bit);
    // [RULE17] [RULE18] [RULE19] status bits
    assign status_w[NFS_SR_WP] = arr_in.wp_n;
    assign status_w[NFS_SR_RDY] = ~arr_in.busy;
    assign status_w[NFS_SR_ARRAY_READY_BIT] = ~(|arr_in.array_busy);
    assign status_w[4:2] = 3'h0;
    assign status_w[NFS_SR_PREV_OP_ERROR_BIT] = prev_op_error_bit_sel;
    assign status_w[NFS_SR_FAIL] = fail_sel;
    assign status_out = status_w;
endmodule : nfs_status_mux

/* nfs_feature_status_asserts.sv */
// Purpose: Port-level checks of the feature registers and the status output.
// Assumes: One core clock with a synchronous active-high reset.
// Notes: Bound to nfs_feature_status from the bench top file.
`timescale 1ns/1ps
module nfs_feature_status_asserts
    import nfs_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // Register port.
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    // Host pins and array state.
    input wire nfs_bus_t bus_in,
    input wire nfs_array_t arr_in,
    // Outputs under watch.
    input wire logic [7:0] dq_out,
    input wire logic dq_oe_out,
    input wire logic dqs_out,
    input wire logic dqs_oe_out,
    input wire logic [1:0] pulldown_strength_out,
    input wire logic [1:0] read_retry_out,
    input wire logic otp_mode_out,
    input wire logic status_mode_out
);
    // ==========================================================
    // Checks
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    // A status read on the register port.
    sequence s_stat_rd;
        reg_rd_in && reg_addr_in == NFS_ADDR_STATUS;
    endsequence
    // An asynchronous read window held open in status mode; six cycles cover the pin synchroniser.
    sequence s_async_open;
        (status_mode_out && !bus_in.ce_n && !bus_in.read_strobe_n && !bus_in.sync_mode) [*6];
    endsequence

    a_feat_reset_zero: assert property ($past(sys_rst_in) |->
        {pulldown_strength_out, read_retry_out, otp_mode_out} == 5'h00) else $error("features not cleared by reset");
    a_pd_write_field: assert property (reg_wr_in && reg_addr_in == NFS_ADDR_PULLDOWN |=>
        pulldown_strength_out == $past(reg_wdata_in[1:0])) else $error("pull-down field not taken");
    a_retry_write_field: assert property (reg_wr_in && reg_addr_in == NFS_ADDR_RETRY |=>
        read_retry_out == $past(reg_wdata_in[1:0])) else $error("retry field not taken");
    a_otp_write_bit: assert property (reg_wr_in && reg_addr_in == NFS_ADDR_ARRAY_MODE |=>
        otp_mode_out == $past(reg_wdata_in[0])) else $error("array mode bit not taken");
    a_ready_bits_read: assert property (s_stat_rd |=> reg_rdata_out[7:5] ==
        {$past(arr_in.wp_n), !$past(arr_in.busy), !(|$past(arr_in.array_busy))}) else $error("ready bits wrong");
    a_dq_live_status: assert property (dq_oe_out && $past(dq_oe_out) |-> dq_out[7:2] ==
        {$past(arr_in.wp_n), !$past(arr_in.busy), !(|$past(arr_in.array_busy)), 3'h0}) else $error("dq not status");
    a_dq_quiet_idle: assert property (!status_mode_out && $past(!status_mode_out) |->
        !dq_oe_out) else $error("dq driven outside status mode");
    a_async_live_out: assert property (s_async_open |-> dq_oe_out) else $error("async window not driven");
    // A synchronous read window held open in status mode; six cycles cover the pin synchroniser.
    sequence s_sync_open;
        (status_mode_out && !bus_in.ce_n && !bus_in.wr_n && bus_in.ale && bus_in.cle && bus_in.sync_mode) [*6];
    endsequence
    a_sync_live_out: assert property (s_sync_open |-> dq_oe_out && dqs_oe_out) else $error("sync window idle");
    a_dqs_toggles: assert property (dqs_oe_out && $past(dqs_oe_out) |->
        dqs_out != $past(dqs_out)) else $error("strobe stalled");
endmodule : nfs_feature_status_asserts

/* nfs_host_model.sv */
// Purpose: Behavioural host flash controller driving the die's pins.
// Assumes: Each write strobe phase of a latch cycle is held three core cycles so the synchroniser sees it.
// Notes: Data lines show the inverse of the last byte once a latch cycle ends.
`timescale 1ns/1ps
module nfs_host_model
    import nfs_pkg::*;
(
    // Clock.
    input wire logic core_clk_in,
    // Host pins.
    output nfs_bus_t bus_out
);
    // ==========================================================
    // Pin drivers
    nfs_bus_t b_q = 15'h4e00; // Idle: chip enable, write, read and direction all high.
    assign bus_out = b_q;

    // One latched cycle: command when c is set, address when a is set.
    task automatic latch(input logic c, input logic a, input logic [7:0] v);
        @(posedge core_clk_in);
        b_q.ce_n <= 1'b0;
        b_q.cle <= c;
        b_q.ale <= a;
        b_q.dq <= v;
        b_q.we_n <= 1'b0;
        repeat (3) @(posedge core_clk_in);
        b_q.we_n <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        b_q.cle <= 1'b0;
        b_q.ale <= 1'b0;
        b_q.dq <= ~v;
    endtask : latch

    // Opens or closes a read window; the write strobe stays high so nothing is latched.
    task automatic window(input logic sync, input logic open);
        @(posedge core_clk_in);
        b_q.ce_n <= !open;
        b_q.sync_mode <= sync;
        b_q.read_strobe_n <= !(open && !sync);
        b_q.wr_n <= !(open && sync);
        b_q.cle <= open && sync;
        b_q.ale <= open && sync;
    endtask : window
endmodule : nfs_host_model

/* tb_nfs_feature_status.sv */
// Purpose: Self-checking bench for the feature registers and status output.
// Assumes: Array state is driven by the bench in the core clock domain.
// Notes: Enhanced status addresses plane one in the first case and plane zero in the unselected-die case.
`timescale 1ns/1ps
module tb_nfs_feature_status;
    import nfs_pkg::*;
    // ==========================================================
    // Signals and instances
    logic core_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out, dq_out, rv, d;
    logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, dq_oe_out, dqs_out, dqs_oe_out, otp_mode_out, status_mode_out;
    logic [1:0] pulldown_strength_out, read_retry_out;
    logic [7:0] adr[3] = '{NFS_ADDR_PULLDOWN, NFS_ADDR_RETRY, NFS_ADDR_ARRAY_MODE};
    logic [7:0] msk[3] = '{NFS_MASK_TWO_BITS, NFS_MASK_TWO_BITS, NFS_MASK_ONE_BIT};
    logic [7:0] feat[3] = '{8'h00, 8'h00, 8'h00};
    nfs_bus_t bus_in;
    nfs_array_t arr_in = 9'h003, tmp; // Idle, writable, selected, no failures.
    int err_total = 0, total_checks = 0, cyc = 0, k;

    always #20 core_clk_in = ~core_clk_in;
    nfs_host_model host (.core_clk_in, .bus_out(bus_in));
    nfs_feature_status uut (.core_clk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
        .reg_rdata_out, .bus_in, .arr_in, .dq_out, .dq_oe_out, .dqs_out, .dqs_oe_out, .pulldown_strength_out,
        .read_retry_out, .otp_mode_out, .status_mode_out);

    // ==========================================================
    // Helpers
    function automatic logic [7:0] exp_st(input nfs_array_t a, input logic enh);
        return {a.wp_n, ~a.busy, ~|a.array_busy, 3'h0, enh ? a.prev_op_error_bit[1] : |a.prev_op_error_bit, enh ? a.fail[1] : |a.fail};
    endfunction : exp_st
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= v;
        reg_wr_in <= 1'b1;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge core_clk_in);
        reg_rd_in <= 1'b0;
        #1 rv = reg_rdata_out;
    endtask : rd
    // Bounded wait for a design output to reach a level.
    task automatic wait_sig(ref logic s, input logic v);
        for (int i = 0; i < 30 && s !== v; i++) @(posedge core_clk_in) #1;
    endtask : wait_sig
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    // Hang guard: the sequence needs well under a thousand cycles.
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            tally_and_finish();
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(37));
        repeat (12) @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        for (k = 0; k < 3; k++) begin
            rd(adr[k]);
            chk(rv, 8'h00);
        end
        // Random field values; reserved bits stay zero, as a host must write them.
        for (int i = 0; i < 15; i++) begin
            k = $urandom % 3;
            d = 8'($urandom) & msk[k];
            feat[k] = d;
            wr(adr[k], d);
            rd(adr[k]);
            chk(rv, feat[k]);
            d = {3'h0, feat[0][1:0], feat[1][1:0], feat[2][0]};
            chk({3'h0, pulldown_strength_out, read_retry_out, otp_mode_out}, d);
        end
        wr(8'h55, 8'ha5);
        rd(8'h55);
        chk(rv, 8'h00);
        tmp = nfs_array_t'(9'($urandom));
        tmp.selected = 1'b1;
        arr_in <= tmp;
        rd(NFS_ADDR_STATUS);
        chk(rv, exp_st(tmp, 1'b0));
        wr(NFS_ADDR_ARRAY_MODE, 8'h01);
        // Busy die still answers plain status.
        tmp = 9'h1c3;
        arr_in <= tmp;
        host.latch(1'b1, 1'b0, NFS_CMD_STATUS);
        wait_sig(status_mode_out, 1'b1);
        chk(8'(status_mode_out), 8'h01);
        host.window(1'b0, 1'b1);
        wait_sig(dq_oe_out, 1'b1);
        chk(dq_out, exp_st(tmp, 1'b0));
        tmp = 9'h027;
        arr_in <= tmp;
        repeat (4) @(posedge core_clk_in);
        #1 chk(dq_out, exp_st(tmp, 1'b0));
        host.window(1'b0, 1'b0);
        // Enhanced status, plane one addressed while plane zero failed.
        tmp = 9'h013;
        arr_in <= tmp;
        host.latch(1'b1, 1'b0, NFS_CMD_STATUS_ENH);
        host.latch(1'b0, 1'b1, 8'h01);
        host.latch(1'b0, 1'b1, 8'h00);
        host.latch(1'b0, 1'b1, 8'h00);
        wait_sig(status_mode_out, 1'b1);
        host.window(1'b1, 1'b1);
        wait_sig(dqs_oe_out, 1'b1);
        chk(dq_out, exp_st(tmp, 1'b1));
        d = {7'h00, dqs_out};
        @(posedge core_clk_in) #1;
        chk({7'h00, dqs_out}, ~d & 8'h01);
        host.window(1'b1, 1'b0);
        host.latch(1'b1, 1'b0, NFS_CMD_READ_MODE);
        wait_sig(status_mode_out, 1'b0);
        chk(8'(status_mode_out), 8'h00);
        host.latch(1'b1, 1'b0, NFS_CMD_RESET);
        repeat (4) @(posedge core_clk_in);
        #1 chk(8'(otp_mode_out), 8'h00);
        // A die the enhanced command does not address stays off the data lines.
        tmp.selected = 1'b0;
        arr_in <= tmp;
        host.latch(1'b1, 1'b0, NFS_CMD_STATUS_ENH);
        repeat (3) host.latch(1'b0, 1'b1, 8'h00);
        host.window(1'b0, 1'b1);
        repeat (6) @(posedge core_clk_in);
        #1 chk({6'h00, status_mode_out, dq_oe_out}, 8'h00);
        host.window(1'b0, 1'b0);
        tally_and_finish();
    end
endmodule : tb_nfs_feature_status

bind nfs_feature_status nfs_feature_status_asserts chk_u (.core_clk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .bus_in, .arr_in, .dq_out, .dq_oe_out, .dqs_out, .dqs_oe_out,
    .pulldown_strength_out, .read_retry_out, .otp_mode_out, .status_mode_out);
